// >>> logic/lv_monitor_ctrl.v
// Purpose: Control and status of the supply low-voltage monitor, AHB-Lite slave.
// Assumes: Comparator output is asynchronous; sleep and idle come from the core.
// Notes:
// Functional notes
// - Decode threshold select into eight trip levels.
// - Flag at bit five shows supply below level.
// - Detector enable switches monitor on and off.
// - Bandgap on for monitor, reset function, buffer bit.
// - Top two control bits unstored, read zero.
// - Sleep forces monitor off.
// - Request set only after flag delay elapses.
// - Rising request wakes from sleep or idle.
// - Repeated flag transitions are tolerated.
// - Servicing clears global enable and request.
// - Wake-up ignores the interrupt enable.
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lv_monitor_regs.vh"
module lv_monitor_ctrl (
	// Clock and reset
	input  wire        clock,
	input  wire        rstn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// Analog side
	input  wire        comparatorLow,
	input  wire        lowVoltageResetEnable,
	output reg  [7:0]  tripLevel,
	output wire        monitorPowerOn,
	output wire        bandgapOn,
	// Power mode and interrupt controller
	input  wire        sleepMode,
	input  wire        idleMode,
	input  wire        serviceAck,
	output wire        lvServiceRequest,
	output reg         wakeUp,
	output wire        irq
);
	reg  [4:0] ctrl;
	reg  [2:0] status;
	reg  [2:0] mask;
	reg        lvIntEnable;
	reg        globalIntEnable;
	reg        cmpMeta;
	reg        cmpSync;
	reg        flagPrev;
	reg        reqPrev;
	reg        wrPend;
	reg  [7:0] wrAddr;
	wire       delayDone;
	wire       lowVoltageFlag;
	wire       wrNow;
	wire [2:0] next_status;
	wire       reqRise;
	wire       svc;
	wire       gieWrite;
	wire       gieWval;
	wire [2:0] w1c;
	wire [2:0] events;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Monitor is off in sleep even if enabled; the analog side needs no clock then.
	assign monitorPowerOn = ctrl[`LVM_DETEN_BIT] & ~sleepMode;
	assign bandgapOn = monitorPowerOn | lowVoltageResetEnable | ctrl[`LVM_BGBUF_BIT];

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tripLevel <= 8'h00;
		end else begin
			case (ctrl[2:0])
			3'h0: tripLevel <= 8'h14;
			3'h1: tripLevel <= 8'h16;
			3'h2: tripLevel <= 8'h18;
			3'h3: tripLevel <= 8'h1b;
			3'h4: tripLevel <= 8'h1e;
			3'h5: tripLevel <= 8'h21;
			3'h6: tripLevel <= 8'h24;
			default: tripLevel <= 8'h28;
			endcase
		end
	end

	// Only cmpSync is read; cmpMeta feeds nothing else.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cmpMeta <= 1'b0;
			cmpSync <= 1'b0;
		end else begin
			cmpMeta <= comparatorLow;
			cmpSync <= cmpMeta;
		end
	end

	// A powered-off comparator reports no low supply.
	assign lowVoltageFlag = cmpSync & monitorPowerOn;

	lv_flag_delay #(
		.DELAY (`LVM_FLAG_DELAY_CYC)
	) flagDelay (
		.clock   (clock),
		.rstn    (rstn),
		.flagIn  (lowVoltageFlag),
		.expired (delayDone)
	);

	// Write handling: address phase captured, data applied in the data phase.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
		end else if (hready) begin
			wrPend <= hsel & htrans[1] & hwrite;
			wrAddr <= haddr;
		end
	end
	assign wrNow = wrPend;

	assign w1c = (wrNow && wrAddr == `LVM_STATUS_OFFSET) ? hwdata[2:0] : 3'h0;
	assign gieWrite = wrNow && wrAddr == `LVM_INTCTL_OFFSET;
	assign gieWval  = hwdata[`LVM_INT_GIE_BIT];

	assign lvServiceRequest = status[`LVM_ST_REQ_BIT] & lvIntEnable & globalIntEnable;
	assign svc = serviceAck & lvServiceRequest;

	// Flag edges are counted as events every time; chatter near the trip is expected.
	assign events[`LVM_ST_REQ_BIT]  = delayDone;
	assign events[`LVM_ST_RISE_BIT] = lowVoltageFlag & ~flagPrev;
	assign events[`LVM_ST_FALL_BIT] = ~lowVoltageFlag & flagPrev;

	// Set wins over a software or service clear.
	assign next_status = (status & ~w1c & ~{2'b00, svc}) | events;

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl            <= 5'h00;
			status          <= 3'h0;
			mask            <= 3'h0;
			lvIntEnable     <= 1'b0;
			globalIntEnable <= 1'b0;
			flagPrev        <= 1'b0;
		end else begin
			flagPrev <= lowVoltageFlag;
			status   <= next_status;
			if (wrNow && wrAddr == `LVM_CTRL_OFFSET) begin
				ctrl <= hwdata[4:0];
			end
			if (wrNow && wrAddr == `LVM_MASK_OFFSET) begin
				mask <= hwdata[2:0];
			end
			if (gieWrite) begin
				lvIntEnable <= hwdata[`LVM_INT_LVE_BIT];
			end
			if (svc) begin
				globalIntEnable <= 1'b0;
			end else if (gieWrite) begin
				globalIntEnable <= gieWval;
			end
		end
	end

	// Wake on a rising request only; an already-set request gives no wake.
	assign reqRise = next_status[`LVM_ST_REQ_BIT] & ~reqPrev;
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reqPrev <= 1'b0;
			wakeUp  <= 1'b0;
		end else begin
			reqPrev <= next_status[`LVM_ST_REQ_BIT];
			wakeUp  <= reqRise & (sleepMode | idleMode);
		end
	end

	assign irq = |(status & mask);

	// Read data for the data phase.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr)
			`LVM_CTRL_OFFSET:   hrdata <= {26'h0, lowVoltageFlag, ctrl};
			`LVM_STATUS_OFFSET: hrdata <= {29'h0, status};
			`LVM_MASK_OFFSET:   hrdata <= {29'h0, mask};
			`LVM_INTCTL_OFFSET: hrdata <= {29'h0, lvServiceRequest, globalIntEnable,
				lvIntEnable};
			default:            hrdata <= 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> logic/lv_monitor_regs.vh
// Purpose: Constants of the supply low-voltage monitor control block.
// Assumes: Included by bare name from the design files.
// Notes:   Offsets are byte addresses on the register bus.
`ifndef LV_MONITOR_REGS_VH
`define LV_MONITOR_REGS_VH

`define LVM_CTRL_OFFSET    8'h00
`define LVM_STATUS_OFFSET  8'h04
`define LVM_MASK_OFFSET    8'h08
`define LVM_INTCTL_OFFSET  8'h0c

`define LVM_CTRL_RESET     8'h00
`define LVM_CTRL_WMASK     8'h1f
`define LVM_THR_LSB        0
`define LVM_BGBUF_BIT      3
`define LVM_DETEN_BIT      4
`define LVM_FLAG_BIT       5

`define LVM_ST_REQ_BIT     0
`define LVM_ST_RISE_BIT    1
`define LVM_ST_FALL_BIT    2
`define LVM_ST_WIDTH       3

`define LVM_INT_LVE_BIT    0
`define LVM_INT_GIE_BIT    1
`define LVM_INT_SVC_BIT    2

`define LVM_CLK_MHZ        200
`define LVM_FLAG_DELAY_US  15
`define LVM_FLAG_DELAY_CYC (`LVM_FLAG_DELAY_US * `LVM_CLK_MHZ)

`endif

// >>> logic/lv_flag_delay.v
// Purpose: Holds off the interrupt request until the flag has stayed high.
// Assumes: flagIn is already synchronous to clock.
// Notes:   A drop of the flag restarts the wait.
`timescale 1ns/1ps
`default_nettype none
module lv_flag_delay #(
	parameter DELAY = 3000
) (
	// Clock and reset
	input  wire        clock,
	input  wire        rstn,
	// Flag in, qualified event out
	input  wire        flagIn,
	output reg         expired
);
	reg [15:0] count;

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count   <= 16'h0000;
			expired <= 1'b0;
		end else if (!flagIn) begin
			count   <= 16'h0000;
			expired <= 1'b0;
		end else if (count == DELAY[15:0] - 16'h0001) begin
			count   <= count + 16'h0001;
			expired <= 1'b1;
		end else begin
			count   <= (count == DELAY[15:0]) ? count : count + 16'h0001;
			expired <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> bench/lv_monitor_checker.sv
// Purpose: Port-level checks of the low-voltage monitor.
// Assumes: Bound to lv_monitor_ctrl; one clock domain.
// Notes:   Register contents are judged by the bench, not here.
`timescale 1ns/1ps
`default_nettype none
module lv_monitor_checker (
	// Clock and reset
	input wire logic       clock,
	input wire logic       rstn,
	// Mode and analog side
	input wire logic       sleepMode,
	input wire logic       idleMode,
	input wire logic       lowVoltageResetEnable,
	input wire logic       monitorPowerOn,
	input wire logic       bandgapOn,
	input wire logic [7:0] tripLevel,
	// Interrupt side and bus
	input wire logic       serviceAck,
	input wire logic       lvServiceRequest,
	input wire logic       wakeUp,
	input wire logic       hreadyout,
	input wire logic       hresp
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence svcTaken;
		serviceAck && lvServiceRequest;
	endsequence
	sequence wakePulse;
		wakeUp ##1 !wakeUp;
	endsequence
	sleep_off_a: assert property (sleepMode |-> !monitorPowerOn)
		else $error("monitor powered in sleep");
	bg_monitor_a: assert property (monitorPowerOn |-> bandgapOn)
		else $error("bandgap off with monitor on");
	bg_reset_a: assert property (lowVoltageResetEnable |-> bandgapOn)
		else $error("bandgap off with reset function on");
	trip_range_a: assert property ($past(rstn) |-> tripLevel inside {[8'h14:8'h28]})
		else $error("trip level out of range");
	wake_mode_a: assert property (wakeUp |-> $past(sleepMode) || $past(idleMode))
		else $error("wake outside sleep or idle");
	wake_pulse_a: assert property (wakeUp |-> wakePulse)
		else $error("wake longer than one cycle");
	svc_clear_a: assert property (svcTaken |=> !lvServiceRequest)
		else $error("service did not clear request");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready okay");
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Purpose: Self-checking bench of the low-voltage monitor.
// Assumes: Zero-wait slave, flag delay of 3000 cycles.
// Notes:   Idle is held in the long wait, so one wake is expected.
`timescale 1ns/1ps
`default_nettype none
`include "lv_monitor_regs.vh"
module tb;
	logic        clock = 0, rstn = 0, hsel = 0, hwrite = 0, cmp = 0;
	logic        low_voltage_reset = 0, slp = 0, idl = 0, ack = 0;
	logic [7:0]  haddr = 0, trip;
	logic [1:0]  htrans = 0;
	logic [31:0] hwdata = 0, hrdata, rd;
	logic        ready, hresp, monOn, bgOn, svc, wake, irq;
	int          fails = 0, checksDone = 0, wakes = 0;
	initial forever #2.5 clock = ~clock;
	always @(posedge clock) if (wake === 1'b1) wakes++;
	lv_monitor_ctrl dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(ready), .hrdata(hrdata),
		.hreadyout(ready), .hresp(hresp), .comparatorLow(cmp), .lowVoltageResetEnable(low_voltage_reset),
		.tripLevel(trip), .monitorPowerOn(monOn), .bandgapOn(bgOn), .sleepMode(slp),
		.idleMode(idl), .serviceAck(ack), .lvServiceRequest(svc), .wakeUp(wake), .irq(irq));
	task chk(input [31:0] got, input [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task xfer(input w, input [7:0] a, input [31:0] d);
		@(posedge clock);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clock); while (ready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (ready !== 1'b1);
		rd = hrdata;
	endtask
	task regs_test;
		static logic [7:0] lv [8] = '{8'h14, 8'h16, 8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h28};
		xfer(0, `LVM_CTRL_OFFSET, 0);
		chk(rd, 32'h0);
		xfer(1, `LVM_CTRL_OFFSET, 32'hff);
		xfer(0, `LVM_CTRL_OFFSET, 0);
		chk(rd, 32'h1f);
		chk(monOn, 1);
		xfer(0, 8'h10, 0);
		chk(rd, 32'h0);
		for (int i = 0; i < 8; i++) begin
			xfer(1, `LVM_CTRL_OFFSET, i);
			repeat (2) @(posedge clock);
			chk(trip, lv[i]);
		end
		chk(monOn, 0);
	endtask
	task sleep_test;
		xfer(1, `LVM_CTRL_OFFSET, 32'h18);
		slp <= 1;
		@(posedge clock);
		chk(monOn, 0);
		chk(bgOn, 1);
		xfer(1, `LVM_CTRL_OFFSET, 32'h10);
		@(posedge clock);
		chk(bgOn, 0);
		low_voltage_reset <= 1;
		@(posedge clock);
		chk(bgOn, 1);
		low_voltage_reset <= 0;
		slp <= 0;
	endtask
	task lv_test;
		xfer(1, `LVM_CTRL_OFFSET, 32'h10);
		xfer(1, `LVM_STATUS_OFFSET, 32'h7);
		xfer(1, `LVM_MASK_OFFSET, 32'h1);
		idl <= 1;
		cmp <= 1;
		repeat (4) @(posedge clock);
		xfer(0, `LVM_CTRL_OFFSET, 0);
		chk(rd, 32'h30);
		cmp <= 0;
		repeat (4) @(posedge clock);
		cmp <= 1;
		// The drop above restarts the hold-off, so timing counts from here.
		repeat (2985) @(posedge clock);
		xfer(0, `LVM_STATUS_OFFSET, 0);
		chk(rd[0], 0);
		chk(irq, 0);
		repeat (40) @(posedge clock);
		xfer(0, `LVM_STATUS_OFFSET, 0);
		chk(rd, 32'h7);
		chk(irq, 1);
		chk(wakes, 1);
		xfer(1, `LVM_INTCTL_OFFSET, 32'h3);
		// The enable lands on the edge the transfer returns at, so look one edge later.
		@(posedge clock);
		chk(svc, 1);
		ack <= 1;
		@(posedge clock);
		ack <= 0;
		xfer(0, `LVM_INTCTL_OFFSET, 0);
		chk(rd, 32'h1);
		xfer(1, `LVM_STATUS_OFFSET, 32'h2);
		xfer(0, `LVM_STATUS_OFFSET, 0);
		chk(rd, 32'h4);
		chk(irq, 0);
	endtask
	task give_verdict;
		$display("checks %0d fails %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		rstn <= 1;
		regs_test;
		sleep_test;
		lv_test;
		give_verdict;
	end
	initial begin
		#60000;
		fails++;
		give_verdict;
	end
endmodule
bind lv_monitor_ctrl lv_monitor_checker chkr (.clock(clock), .rstn(rstn), .sleepMode(sleepMode),
	.idleMode(idleMode), .lowVoltageResetEnable(lowVoltageResetEnable),
	.monitorPowerOn(monitorPowerOn), .bandgapOn(bandgapOn), .tripLevel(tripLevel),
	.serviceAck(serviceAck), .lvServiceRequest(lvServiceRequest), .wakeUp(wakeUp),
	.hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire
